// ### common/sldc_pkg.sv
package sldc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int WORD_W = 32;
    localparam int PAY_W = 20;
    localparam int LANE_DATA_W = 16;
    localparam int LANES = 4;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 5;
    localparam int GAP_W = 7;
    localparam int LOCK_CNT_W = 3;
    localparam int TX_LOCK_W = 5;
    localparam int RC_W = 3;

    // ****************************************
    // Payload framing
    // ****************************************
    localparam logic [1:0] EMB_CLOCK = 2'h2;
    localparam logic [CNT_W-1:0] PAY_BITS = 5'h14;
    localparam logic [CNT_W-1:0] RX_BODY_BITS = 5'h12;

    // ****************************************
    // Lock counts (parallel clock edges, good payloads) and timing counts in ref clock cycles
    // ****************************************
    localparam logic [TX_LOCK_W-1:0] TX_LOCK_EDGES = 5'h10;
    localparam logic [LOCK_CNT_W-1:0] RX_LOCK_GOOD = 3'h4;
    localparam logic [GAP_W-1:0] RX_GAP_MAX = 7'h40;
    localparam logic [RC_W-1:0] RCLK_HALF = 3'h4;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RXDATA = 4'h8;
    localparam logic [3:0] REG_TXDATA = 4'hC;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int CTRL_TX_PD_N = 0;
    localparam int CTRL_TX_EDGE = 1;
    localparam int CTRL_QUAD = 2;
    localparam int CTRL_PREEMPH = 3;
    localparam int CTRL_SWING = 4;
    localparam int CTRL_RX_PD_N = 5;
    localparam int CTRL_RX_OE = 6;
    localparam int CTRL_RX_EDGE = 7;

    // ****************************************
    // Shared encoding
    // ****************************************
    function automatic logic [PAY_W-1:0] build_payload(input logic [LANE_DATA_W-1:0] d);
        build_payload = {EMB_CLOCK, d, ^d, ~^d};
    endfunction : build_payload

    function automatic logic [BYTE_W-1:0] lane_byte(input logic [WORD_W-1:0] w, input int k);
        lane_byte = w[k*BYTE_W +: BYTE_W];
    endfunction : lane_byte

endpackage : sldc_pkg

// ### design/sldc_tx_lane.sv
`timescale 1ns/1ns
module sldc_tx_lane (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [sldc_pkg::LANE_DATA_W-1:0] i_data,
    input wire logic i_boost_en,
    output logic o_bit,
    output logic o_boost
);
    logic [sldc_pkg::PAY_W-1:0] sh_q;
    logic [sldc_pkg::CNT_W-1:0] cnt_q;
    logic bit_q;
    logic boost_q;
    logic bit_d;

    assign bit_d = (cnt_q != '0) ? sh_q[sldc_pkg::PAY_W-1] : 1'b0;

    // ****************************************
    // Payload shifter
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            sh_q <= '0;
            cnt_q <= '0;
        end else if (i_load) begin
            sh_q <= sldc_pkg::build_payload(i_data);
            cnt_q <= sldc_pkg::PAY_BITS;
        end else if (cnt_q != '0) begin
            sh_q <= {sh_q[sldc_pkg::PAY_W-2:0], 1'b0};
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // ****************************************
    // Line bit and boost
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            bit_q <= 1'b0;
            boost_q <= 1'b0;
        end else begin
            bit_q <= bit_d;
            boost_q <= i_boost_en & (bit_d != bit_q);
        end
    end

    assign o_bit = bit_q;
    assign o_boost = boost_q;

endmodule : sldc_tx_lane

// ### design/sldc_rx_lane.sv
`timescale 1ns/1ns
module sldc_rx_lane (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_enable,
    input wire logic i_allow,
    input wire logic i_bit,
    output logic o_valid,
    output logic [sldc_pkg::LANE_DATA_W-1:0] o_data,
    output logic o_miss,
    output logic o_locked,
    output logic o_active
);
    typedef enum logic [1:0] {RX_HUNT, RX_CLOCK, RX_BODY} sldc_rx_st_t;
    sldc_rx_st_t st_q;
    logic [sldc_pkg::PAY_W-3:0] sh_q;
    logic [sldc_pkg::PAY_W-3:0] full;
    logic [sldc_pkg::CNT_W-1:0] cnt_q;
    logic [sldc_pkg::GAP_W-1:0] gap_q;
    logic [sldc_pkg::LOCK_CNT_W-1:0] good_q;
    logic last;
    logic par_ok;
    logic good;
    logic err;
    logic timeout;

    assign full = {sh_q[sldc_pkg::PAY_W-4:0], i_bit};
    assign last = (st_q == RX_BODY) && (cnt_q == 5'h01);
    assign par_ok = full[1:0] == {^full[17:2], ~^full[17:2]};
    assign good = last & par_ok;
    assign err = ((st_q == RX_CLOCK) & i_bit) | (last & ~par_ok);
    assign timeout = o_locked & (gap_q == sldc_pkg::RX_GAP_MAX - 1'b1);

    // ****************************************
    // Framer
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !i_enable) begin
            st_q <= RX_HUNT;
            cnt_q <= '0;
            sh_q <= '0;
        end else begin
            sh_q <= full;
            unique case (st_q)
                RX_HUNT: begin
                    if (i_bit) begin
                        st_q <= RX_CLOCK;
                    end
                end
                RX_CLOCK: begin
                    st_q <= i_bit ? RX_HUNT : RX_BODY;
                    cnt_q <= sldc_pkg::RX_BODY_BITS;
                end
                RX_BODY: begin
                    cnt_q <= cnt_q - 1'b1;
                    if (last) begin
                        st_q <= RX_HUNT;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Activity, lock and outputs
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !i_enable) begin
            gap_q <= sldc_pkg::RX_GAP_MAX;
            good_q <= '0;
            o_valid <= 1'b0;
            o_data <= '0;
            o_miss <= 1'b0;
        end else begin
            if (good) begin
                gap_q <= '0;
            end else if (gap_q != sldc_pkg::RX_GAP_MAX) begin
                gap_q <= gap_q + 1'b1;
            end
            if (err || timeout) begin
                good_q <= '0;
            end else if (good && i_allow && !o_locked) begin
                good_q <= good_q + 1'b1;
            end
            o_valid <= good;
            o_miss <= err | timeout;
            if (good) begin
                o_data <= full[17:2];
            end
        end
    end

    assign o_locked = good_q == sldc_pkg::RX_LOCK_GOOD;
    assign o_active = gap_q != sldc_pkg::RX_GAP_MAX;

endmodule : sldc_rx_lane

// ### design/sldc_top.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module sldc_top (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_tx_parallel_clock,
    input wire logic [sldc_pkg::WORD_W-1:0] i_tx_parallel_word,
    output logic [sldc_pkg::LANES-1:0] o_serial_lane_out,
    output logic [sldc_pkg::LANES-1:0] o_serial_lane_oe_n,
    output logic [sldc_pkg::LANES-1:0] o_lane_boost,
    output logic o_swing_select,
    input wire logic [sldc_pkg::LANES-1:0] i_serial_lane_in,
    output logic [sldc_pkg::WORD_W-1:0] o_rx_parallel_word,
    output logic o_rx_word_oe_n,
    output logic o_recovered_clock_out,
    output logic o_recovered_clock_oe_n,
    output logic o_lock
);
    localparam int L = sldc_pkg::LANES;
    localparam int DW = sldc_pkg::LANE_DATA_W;
    localparam int BW = sldc_pkg::BYTE_W;

    typedef enum logic [1:0] {RC_IDLE, RC_LEAD, RC_TRAIL} sldc_rc_st_t;

    logic [7:0] ctrl_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [2:0] pclk_sync_q;
    logic [sldc_pkg::WORD_W-1:0] word_s1_q;
    logic [sldc_pkg::WORD_W-1:0] word_s2_q;
    logic [L-1:0] lane_s1_q;
    logic [L-1:0] lane_s2_q;
    logic tx_pd_n;
    logic tx_quad;
    logic cap_edge;
    logic [sldc_pkg::TX_LOCK_W-1:0] tx_lock_cnt_q;
    logic tx_locked;
    logic tx_phase_q;
    logic [sldc_pkg::WORD_W-1:0] tx_first_q;
    logic [sldc_pkg::WORD_W-1:0] tx_word_q;
    logic [L-1:0] tx_load;
    logic [DW-1:0] tx_data [L];
    logic [L-1:0] tx_bit;
    logic [L-1:0] tx_boost;
    logic rx_en;
    logic [L-1:0] rx_valid;
    logic [DW-1:0] rx_data [L];
    logic [L-1:0] rx_miss;
    logic [L-1:0] rx_locked;
    logic [L-1:0] rx_active;
    logic [L-1:0] rx_mask;
    logic rx_quad;
    logic rx_all_locked;
    logic rx_lock_q;
    logic rx_lock_now;
    logic [L-1:0] got_q;
    logic [L-1:0] got_all;
    logic [DW-1:0] pay_q [L];
    logic [DW-1:0] pay_now [L];
    logic assemble;
    logic [sldc_pkg::WORD_W-1:0] word_a;
    logic [sldc_pkg::WORD_W-1:0] word_b;
    logic [sldc_pkg::WORD_W-1:0] rx_word_q;
    logic [sldc_pkg::WORD_W-1:0] rx_next_q;
    logic rx_pend_q;
    sldc_rc_st_t rc_st_q;
    logic [sldc_pkg::RC_W-1:0] rc_cnt_q;
    logic rclk_q;
    logic rx_float;

    // ****************************************
    // Avalon-MM register slave
    // ****************************************
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ctrl_q <= sldc_pkg::CTRL_RST;
        end else if (i_avs_write && ack_q && i_avs_byteenable[0]
                     && i_avs_address == sldc_pkg::REG_CTRL) begin
            ctrl_q <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rdata_q <= '0;
        end else if (i_avs_read && !ack_q) begin
            unique case (i_avs_address)
                sldc_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_q};
                sldc_pkg::REG_STATUS: rdata_q <= {20'h00000, rx_active, rx_locked,
                                                  1'b0, rx_quad, o_lock, tx_locked};
                sldc_pkg::REG_RXDATA: rdata_q <= rx_word_q;
                sldc_pkg::REG_TXDATA: rdata_q <= tx_word_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_swing_select = ctrl_q[sldc_pkg::CTRL_SWING];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            pclk_sync_q <= '0;
            word_s1_q <= '0;
            word_s2_q <= '0;
            lane_s1_q <= '0;
            lane_s2_q <= '0;
        end else begin
            pclk_sync_q <= {pclk_sync_q[1:0], i_tx_parallel_clock};
            word_s1_q <= i_tx_parallel_word;
            word_s2_q <= word_s1_q;
            lane_s1_q <= i_serial_lane_in;
            lane_s2_q <= lane_s1_q;
        end
    end

    // ****************************************
    // Serializer capture and PLL lock
    // ****************************************
    assign tx_pd_n = ctrl_q[sldc_pkg::CTRL_TX_PD_N];
    assign tx_quad = ctrl_q[sldc_pkg::CTRL_QUAD];
    assign cap_edge = ctrl_q[sldc_pkg::CTRL_TX_EDGE]
                      ? (pclk_sync_q[1] & ~pclk_sync_q[2])
                      : (~pclk_sync_q[1] & pclk_sync_q[2]);
    assign tx_locked = tx_lock_cnt_q == sldc_pkg::TX_LOCK_EDGES;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !tx_pd_n) begin
            tx_lock_cnt_q <= '0;
        end else if (cap_edge && !tx_locked) begin
            tx_lock_cnt_q <= tx_lock_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !tx_locked || !tx_quad) begin
            tx_phase_q <= 1'b0;
            tx_first_q <= '0;
        end else if (cap_edge) begin
            tx_phase_q <= ~tx_phase_q;
            if (!tx_phase_q) begin
                tx_first_q <= word_s2_q;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            tx_word_q <= '0;
        end else if (cap_edge && tx_locked) begin
            tx_word_q <= word_s2_q;
        end
    end

    // ****************************************
    // Lane mapping and serial lanes
    // ****************************************
    generate
        for (genvar k = 0; k < L; k++) begin : g_tx
            if (k < 2) begin : g_low
                assign tx_load[k] = cap_edge & tx_locked & (~tx_quad | tx_phase_q);
            end else begin : g_high
                assign tx_load[k] = cap_edge & tx_locked & tx_quad & tx_phase_q;
            end
            assign tx_data[k] = tx_quad
                ? {sldc_pkg::lane_byte(word_s2_q, k), sldc_pkg::lane_byte(tx_first_q, k)}
                : word_s2_q[(k % 2)*DW +: DW];

            sldc_tx_lane u_tx_lane (
                .i_ref_clk(i_ref_clk),
                .i_rstn(i_rstn),
                .i_load(tx_load[k]),
                .i_data(tx_data[k]),
                .i_boost_en(ctrl_q[sldc_pkg::CTRL_PREEMPH]),
                .o_bit(tx_bit[k]),
                .o_boost(tx_boost[k])
            );

            assign o_serial_lane_out[k] = tx_bit[k];
            assign o_lane_boost[k] = tx_boost[k] & ~o_serial_lane_oe_n[k];
            if (k < 2) begin : g_oe_low
                assign o_serial_lane_oe_n[k] = ~tx_pd_n;
            end else begin : g_oe_high
                assign o_serial_lane_oe_n[k] = ~tx_pd_n | ~tx_quad;
            end
        end
    endgenerate

    // ****************************************
    // Deserializer lanes
    // ****************************************
    assign rx_en = ctrl_q[sldc_pkg::CTRL_RX_PD_N];

    generate
        for (genvar k = 0; k < L; k++) begin : g_rx
            sldc_rx_lane u_rx_lane (
                .i_ref_clk(i_ref_clk),
                .i_rstn(i_rstn),
                .i_enable(rx_en),
                .i_allow((k == 0) ? 1'b1 : rx_locked[0]),
                .i_bit(lane_s2_q[k]),
                .o_valid(rx_valid[k]),
                .o_data(rx_data[k]),
                .o_miss(rx_miss[k]),
                .o_locked(rx_locked[k]),
                .o_active(rx_active[k])
            );
            assign pay_now[k] = rx_valid[k] ? rx_data[k] : pay_q[k];
        end
    endgenerate

    // ****************************************
    // Mode detection and lock
    // ****************************************
    assign rx_quad = rx_active[2] & rx_active[3];
    assign rx_mask = rx_quad ? 4'hF : 4'h3;
    assign rx_all_locked = &(rx_locked | ~rx_mask);
    assign rx_lock_now = rx_lock_q & ~|(rx_miss & rx_mask);
    assign o_lock = rx_lock_now;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !rx_en) begin
            rx_lock_q <= 1'b0;
        end else begin
            rx_lock_q <= rx_all_locked & ~|(rx_miss & rx_mask);
        end
    end

    // ****************************************
    // Word reassembly
    // ****************************************
    assign got_all = got_q | rx_valid;
    assign assemble = rx_lock_q && ((got_all & rx_mask) == rx_mask);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !rx_lock_now) begin
            got_q <= '0;
        end else if (assemble) begin
            got_q <= '0;
        end else begin
            got_q <= got_all & rx_mask;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            for (int k = 0; k < L; k++) begin
                pay_q[k] <= '0;
            end
        end else begin
            for (int k = 0; k < L; k++) begin
                pay_q[k] <= pay_now[k];
            end
        end
    end

    always_comb begin
        word_a = {pay_now[1], pay_now[0]};
        word_b = '0;
        if (rx_quad) begin
            for (int k = 0; k < L; k++) begin
                word_a[k*BW +: BW] = pay_now[k][BW-1:0];
                word_b[k*BW +: BW] = pay_now[k][DW-1:BW];
            end
        end
    end

    // ****************************************
    // Recovered clock and data output
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !rx_lock_now) begin
            rc_st_q <= RC_IDLE;
            rc_cnt_q <= '0;
            rclk_q <= ctrl_q[sldc_pkg::CTRL_RX_EDGE];
            rx_pend_q <= 1'b0;
        end else begin
            unique case (rc_st_q)
                RC_IDLE: begin
                    if (assemble) begin
                        rc_st_q <= RC_LEAD;
                        rc_cnt_q <= sldc_pkg::RCLK_HALF;
                        rclk_q <= ~ctrl_q[sldc_pkg::CTRL_RX_EDGE];
                        rx_pend_q <= rx_quad;
                    end
                end
                RC_LEAD: begin
                    rc_cnt_q <= rc_cnt_q - 1'b1;
                    if (rc_cnt_q == 3'h1) begin
                        rc_st_q <= RC_TRAIL;
                        rc_cnt_q <= sldc_pkg::RCLK_HALF;
                        rclk_q <= ctrl_q[sldc_pkg::CTRL_RX_EDGE];
                    end
                end
                RC_TRAIL: begin
                    rc_cnt_q <= rc_cnt_q - 1'b1;
                    if (rc_cnt_q == 3'h1) begin
                        if (rx_pend_q) begin
                            rc_st_q <= RC_LEAD;
                            rc_cnt_q <= sldc_pkg::RCLK_HALF;
                            rclk_q <= ~ctrl_q[sldc_pkg::CTRL_RX_EDGE];
                            rx_pend_q <= 1'b0;
                        end else begin
                            rc_st_q <= RC_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rx_word_q <= '0;
            rx_next_q <= '0;
        end else if (rx_lock_now && rc_st_q == RC_IDLE && assemble) begin
            rx_word_q <= word_a;
            rx_next_q <= word_b;
        end else if (rx_lock_now && rc_st_q == RC_TRAIL && rc_cnt_q == 3'h1 && rx_pend_q) begin
            rx_word_q <= rx_next_q;
        end
    end

    assign rx_float = ~ctrl_q[sldc_pkg::CTRL_RX_OE] | ~rx_en;
    assign o_rx_parallel_word = rx_word_q;
    assign o_rx_word_oe_n = rx_float;
    assign o_recovered_clock_out = rclk_q;
    assign o_recovered_clock_oe_n = rx_float;

endmodule : sldc_top

// ### sim/sldc_top_asserts.sv
`timescale 1ns/1ns
module sldc_top_asserts (
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic o_avs_waitrequest,
    input wire logic [3:0] o_serial_lane_oe_n,
    input wire logic [3:0] o_lane_boost,
    input wire logic [3:0] o_serial_lane_out,
    input wire logic [3:0] i_serial_lane_in,
    input wire logic [31:0] o_rx_parallel_word,
    input wire logic o_rx_word_oe_n,
    input wire logic o_recovered_clock_oe_n,
    input wire logic o_recovered_clock_out,
    input wire logic o_lock
);
    // ****************************************
    // Checks at the ports
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    logic [5:0] ones_q;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || !i_serial_lane_in[0]) ones_q <= 6'h00;
        else if (ones_q != 6'h3F) ones_q <= ones_q + 6'h01;
    end
    sequence s_wait; o_avs_waitrequest ##1 !o_avs_waitrequest; endsequence
    property p_one_wait; $rose(i_avs_read || i_avs_write) |-> s_wait; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
    property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("waitrequest without request");
    property p_pair; o_serial_lane_oe_n[3] == o_serial_lane_oe_n[2]; endproperty
    a_pair: assert property (p_pair) else $error("upper lanes split");
    property p_pd_all; o_serial_lane_oe_n[0] |-> &o_serial_lane_oe_n; endproperty
    a_pd_all: assert property (p_pd_all) else $error("lane driven in power-down");
    property p_rx_oe; o_rx_word_oe_n == o_recovered_clock_oe_n; endproperty
    a_rx_oe: assert property (p_rx_oe) else $error("word and clock enables differ");
    property p_boost; (o_lane_boost & ~(o_serial_lane_out ^ $past(o_serial_lane_out))) == 4'h0;
    endproperty
    a_boost: assert property (p_boost) else $error("boost on repeated bit");
    property p_rclk; $changed(o_rx_parallel_word) |-> $changed(o_recovered_clock_out);
    endproperty
    a_rclk: assert property (p_rclk) else $error("word not aligned to clock");
    property p_word_hold; $changed(o_rx_parallel_word) |=> $stable(o_rx_parallel_word)[*3];
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word not held");
    property p_miss; ones_q >= 6'h1E |-> !o_lock; endproperty
    a_miss: assert property (p_miss) else $error("lock kept with lane 0 stuck");
endmodule : sldc_top_asserts

// ### sim/sldc_peer.sv
`timescale 1ns/1ns
module sldc_peer (
    input wire logic i_break,
    input wire logic [3:0] i_lane_out,
    input wire logic [3:0] i_lane_oe_n,
    output logic o_par_clk,
    output logic [3:0] o_lane_in
);
    // ****************************************
    // Host clock and cable
    // ****************************************
    logic wander = 1'b0;
    initial begin
        o_par_clk = 1'b0;
        forever #80 o_par_clk = ~o_par_clk;
    end
    always #10 wander = ~wander;
    // Floated lanes wander; a break holds lane 0 high
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            o_lane_in[k] = i_lane_oe_n[k] ? wander : i_lane_out[k];
        end
        if (i_break) o_lane_in[0] = 1'b1;
    end
endmodule : sldc_peer

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic i_ref_clk, i_rstn, i_avs_read, i_avs_write, o_avs_waitrequest, i_tx_parallel_clock;
    logic [3:0] i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, o_avs_readdata, i_tx_parallel_word, o_rx_parallel_word;
    logic [3:0] o_serial_lane_out, o_serial_lane_oe_n, o_lane_boost, i_serial_lane_in;
    logic o_swing_select, o_rx_word_oe_n, o_recovered_clock_out, o_recovered_clock_oe_n, o_lock;
    logic brk;
    logic [31:0] q;
    int n_errors = 0;
    int num_checks = 0;
    sldc_top uut (.i_ref_clk, .i_rstn, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
        .i_tx_parallel_clock, .i_tx_parallel_word, .o_serial_lane_out, .o_serial_lane_oe_n,
        .o_lane_boost, .o_swing_select, .i_serial_lane_in, .o_rx_parallel_word,
        .o_rx_word_oe_n, .o_recovered_clock_out, .o_recovered_clock_oe_n, .o_lock);
    sldc_peer u_peer (.i_break(brk), .i_lane_out(o_serial_lane_out),
        .i_lane_oe_n(o_serial_lane_oe_n), .o_par_clk(i_tx_parallel_clock),
        .o_lane_in(i_serial_lane_in));
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        @(posedge i_ref_clk);
        while (o_avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge i_ref_clk);
            n++;
        end
        q = o_avs_readdata;
        check("bus answer", 32'h0, (n == 50) ? 32'h1 : 32'h0);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        @(posedge i_ref_clk);
    endtask : bus
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, q);
    endtask : rd_chk
    task automatic wait_lock(input logic exp, input int max);
        int n;
        n = 0;
        while (o_lock !== exp && n < max) begin
            @(posedge i_ref_clk);
            n++;
        end
        check("lock", {31'h0, exp}, {31'h0, o_lock});
    endtask : wait_lock
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #300000;
        n_errors++;
        complete_run();
    end
    initial begin
        i_rstn = 1'b0;
        i_avs_address = 4'h0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hF;
        i_tx_parallel_word = 32'h89AB4C3D;
        brk = 1'b0;
        repeat (20) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        @(posedge i_ref_clk);
        rd_chk("ctrl reset", sldc_pkg::REG_CTRL, 32'h0);
        rd_chk("unmapped", 4'h2, 32'h0);
        i_avs_byteenable <= 4'hE;
        bus(1'b1, sldc_pkg::REG_CTRL, 32'hFF);
        i_avs_byteenable <= 4'hF;
        rd_chk("ctrl masked", sldc_pkg::REG_CTRL, 32'h0);
        check("tx float", 32'hF, {28'h0, o_serial_lane_oe_n});
        check("lock reset", 32'h0, {31'h0, o_lock});
        $display("test reset done");
        bus(1'b1, sldc_pkg::REG_CTRL, 32'h11);
        check("dual lanes", 32'hC, {28'h0, o_serial_lane_oe_n});
        check("swing", 32'h1, {31'h0, o_swing_select});
        $display("test dual enables done");
        bus(1'b1, sldc_pkg::REG_CTRL, 32'h6F);
        check("quad lanes", 32'h0, {28'h0, o_serial_lane_oe_n});
        wait_lock(1'b1, 4000);
        repeat (80) @(posedge i_ref_clk);
        check("rx word", i_tx_parallel_word, o_rx_parallel_word);
        rd_chk("status", sldc_pkg::REG_STATUS, 32'h0FF7);
        rd_chk("rxdata", sldc_pkg::REG_RXDATA, i_tx_parallel_word);
        rd_chk("txdata", sldc_pkg::REG_TXDATA, i_tx_parallel_word);
        $display("test quad link done");
        brk <= 1'b1;
        wait_lock(1'b0, 200);
        repeat (40) @(posedge i_ref_clk);
        brk <= 1'b0;
        wait_lock(1'b1, 4000);
        $display("test resync done");
        bus(1'b1, sldc_pkg::REG_CTRL, 32'h2F);
        check("rx float", 32'h1, {31'h0, o_rx_word_oe_n});
        check("lock kept", 32'h1, {31'h0, o_lock});
        bus(1'b1, sldc_pkg::REG_CTRL, 32'h0F);
        wait_lock(1'b0, 100);
        bus(1'b1, sldc_pkg::REG_CTRL, 32'h00);
        check("tx pd float", 32'hF, {28'h0, o_serial_lane_oe_n});
        $display("test power-down done");
        complete_run();
    end
endmodule : testbench
bind sldc_top sldc_top_asserts u_chk (.i_ref_clk, .i_rstn, .i_avs_read, .i_avs_write,
    .o_avs_waitrequest, .o_serial_lane_oe_n, .o_lane_boost, .o_serial_lane_out, .i_serial_lane_in,
    .o_rx_parallel_word, .o_rx_word_oe_n, .o_recovered_clock_oe_n, .o_recovered_clock_out,
    .o_lock);
